//--- rtl/nsr_pkg.sv
// package: offsets, field layout and types of the bridge status block
package nsr_pkg;

  // =====================================================================
  // register offsets (byte offsets in configuration space)
  localparam logic [11:0] STATUS_OFFSET    = 12'h079;
  localparam logic [11:0] WRITER_ID_OFFSET = 12'h07a;

  // =====================================================================
  // status bit positions
  localparam int FAR_FUND_BIT   = 0;
  localparam int FAR_HOT_BIT    = 1;
  localparam int FAR_ACTIVE_BIT = 2;
  localparam int FWD_MISS_BIT   = 3;
  localparam int REV_MISS_BIT   = 4;
  localparam int INDEX_ERR_BIT  = 5;
  localparam int CRC_FAIL_BIT   = 6;
  localparam int WINDOW_BIT     = 7;

  // sticky flag mask: every status bit except the live indicator
  localparam logic [7:0] STICKY_MASK = 8'hfb;

  // =====================================================================
  // reset values
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [15:0] WRITER_ID_RESET = 16'h0000;

  // =====================================================================
  // types
  typedef struct packed {
    logic       farFundReset;
    logic       farHotReset;
    logic       farResetActive;
    logic       fwdTableNoMatch;
    logic       revTableNoMatch;
    logic       tableIndexError;
    logic       crcFail;
    logic       crcConsumed;
    logic       windowNoHit;
  } nsr_event_type;

  typedef struct packed {
    logic [7:0] busNum;
    logic [4:0] writerDeviceNum;
    logic [2:0] writerFunctionNum;
  } nsr_writer_id_type;

  typedef struct packed {
    logic              valid;
    nsr_writer_id_type id;
  } nsr_cfg_write_type;

endpackage : nsr_pkg

//--- rtl/nsr_status_regs.sv
// bridge event status and last configuration writer id registers
`timescale 1ns/1ns
module nsr_status_regs
  import nsr_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // configuration register port (byte offset, 16-bit data with byte enables)
  input  wire logic              cfgWrite,
  input  wire logic              cfgRead,
  input  wire logic [11:0]       cfgAddr,
  input  wire logic [15:0]       cfgWriteData,
  input  wire logic [1:0]        cfgByteEn,
  output logic      [15:0]       cfgReadData,
  // datapath events and configuration-write capture
  input  wire nsr_event_type     events,
  input  wire nsr_cfg_write_type cfgWriteSeen,
  // status shown to the bridge
  output logic      [7:0]        statusOut,
  output logic      [15:0]       writerIdOut
);

  // =====================================================================
  // decode
  wire logic       statusHit   = (cfgAddr == STATUS_OFFSET);
  wire logic       idHit       = (cfgAddr == WRITER_ID_OFFSET);
  wire logic       statusWrite = cfgWrite && statusHit && cfgByteEn[0];
  wire logic [7:0] clearMask   = statusWrite ?
                                 (cfgWriteData[7:0] & STICKY_MASK) : 8'h00;

  // =====================================================================
  // event collection
  logic [7:0] setMask;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic       active_reg;
  logic [15:0] writerId_reg;
  logic [15:0] writerId_next;
  logic [15:0] readData_next;

  // ecrc is only checked on forwarded TLPs
  wire logic crcEvent = events.crcFail && !events.crcConsumed;

  always_comb begin
    setMask                 = 8'h00;
    setMask[FAR_FUND_BIT]   = events.farFundReset;
    setMask[FAR_HOT_BIT]    = events.farHotReset;
    setMask[FWD_MISS_BIT]   = events.fwdTableNoMatch;
    setMask[REV_MISS_BIT]   = events.revTableNoMatch;
    setMask[INDEX_ERR_BIT]  = events.tableIndexError;
    setMask[CRC_FAIL_BIT]   = crcEvent;
    setMask[WINDOW_BIT]     = events.windowNoHit;
  end

  // set wins over a same-cycle clear; zero bits of a write leave flags
  assign flags_next = ((flags_reg & ~clearMask) | setMask)
                      & STICKY_MASK;

  // only the writer id captured from hardware, never from software
  assign writerId_next = cfgWriteSeen.valid ? cfgWriteSeen.id
                                            : writerId_reg;

  wire logic [7:0] statusView = flags_reg | (8'(active_reg) << FAR_ACTIVE_BIT);

  assign readData_next = !cfgRead ? 16'h0000 :
                         statusHit ? {8'h00, statusView} :
                         idHit     ? writerId_reg : 16'h0000;

  // =====================================================================
  // storage; only the chip-level reset clears these, bridge-side
  // hot and fundamental resets arrive as events, not as resets
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg    <= STATUS_RESET;
      active_reg   <= 1'b0;
      writerId_reg <= WRITER_ID_RESET;
      cfgReadData  <= 16'h0000;
      statusOut    <= STATUS_RESET;
      writerIdOut  <= WRITER_ID_RESET;
    end else begin
      flags_reg    <= flags_next;
      active_reg   <= events.farResetActive;
      writerId_reg <= writerId_next;
      cfgReadData  <= readData_next;
      statusOut    <= flags_next |
                      (8'(events.farResetActive) << FAR_ACTIVE_BIT);
      writerIdOut  <= writerId_next;
    end
  end

  // =====================================================================
  // checks
  hot_flag_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    events.farHotReset |=> flags_reg[FAR_HOT_BIT])
    else $error("hot reset flag not set");

  fund_flag_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    events.farFundReset |=> flags_reg[FAR_FUND_BIT])
    else $error("fundamental reset flag not set");

  active_follows_a: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 statusView[FAR_ACTIVE_BIT] == $past(events.farResetActive))
    else $error("reset indicator wrong");

  fwd_miss_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    events.fwdTableNoMatch |=> flags_reg[FWD_MISS_BIT])
    else $error("forward miss flag not set");

  rev_miss_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    events.revTableNoMatch |=> flags_reg[REV_MISS_BIT])
    else $error("reverse miss flag not set");

  index_err_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    events.tableIndexError |=> flags_reg[INDEX_ERR_BIT])
    else $error("index error flag not set");

  crc_consumed_a: assert property (@(posedge clock) disable iff (!reset_n)
    (!flags_reg[CRC_FAIL_BIT] && events.crcConsumed && !statusWrite)
    |=> !flags_reg[CRC_FAIL_BIT])
    else $error("consumed tlp set crc flag");

  crc_fail_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    (events.crcFail && !events.crcConsumed) |=> flags_reg[CRC_FAIL_BIT])
    else $error("crc flag not set");

  window_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    events.windowNoHit |=> flags_reg[WINDOW_BIT])
    else $error("window miss flag not set");

  flag_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    (statusWrite && cfgWriteData[WINDOW_BIT] && !events.windowNoHit)
    |=> !flags_reg[WINDOW_BIT])
    else $error("window flag not cleared");

  zero_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (statusWrite && !cfgWriteData[FWD_MISS_BIT] && flags_reg[FWD_MISS_BIT])
    |=> flags_reg[FWD_MISS_BIT])
    else $error("zero write changed flag");

  id_capture_a: assert property (@(posedge clock) disable iff (!reset_n)
    cfgWriteSeen.valid |=> writerId_reg[2:0] ==
      $past(cfgWriteSeen.id.writerFunctionNum)
      && writerId_reg[7:3] == $past(cfgWriteSeen.id.writerDeviceNum)
      && writerId_reg[15:8] == $past(cfgWriteSeen.id.busNum))
    else $error("writer id not captured");

  id_readonly_a: assert property (@(posedge clock) disable iff (!reset_n)
    !cfgWriteSeen.valid |=> $stable(writerId_reg))
    else $error("writer id changed without capture");

  flags_after_reset_a: assert property (@(posedge clock)
    $rose(reset_n) |-> flags_reg == STATUS_RESET)
    else $error("flags not zero after reset");

  // =====================================================================
  // checks: a one written clears a flag unless its event repeats
  fund_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    statusWrite && cfgWriteData[FAR_FUND_BIT] && !events.farFundReset
    |=> !flags_reg[FAR_FUND_BIT])
    else $error("fundamental flag not cleared");

  hot_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    statusWrite && cfgWriteData[FAR_HOT_BIT] && !events.farHotReset
    |=> !flags_reg[FAR_HOT_BIT])
    else $error("hot flag not cleared");

  fwd_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    statusWrite && cfgWriteData[FWD_MISS_BIT] && !events.fwdTableNoMatch
    |=> !flags_reg[FWD_MISS_BIT])
    else $error("forward miss flag not cleared");

  rev_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    statusWrite && cfgWriteData[REV_MISS_BIT] && !events.revTableNoMatch
    |=> !flags_reg[REV_MISS_BIT])
    else $error("reverse miss flag not cleared");

  index_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    statusWrite && cfgWriteData[INDEX_ERR_BIT] && !events.tableIndexError
    |=> !flags_reg[INDEX_ERR_BIT])
    else $error("index error flag not cleared");

  crc_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    statusWrite && cfgWriteData[CRC_FAIL_BIT] && !events.crcFail
    |=> !flags_reg[CRC_FAIL_BIT])
    else $error("crc flag not cleared");

  // =====================================================================
  // checks: a set flag stays set unless a one is written to it
  fund_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    flags_reg[FAR_FUND_BIT] && !(statusWrite && cfgWriteData[FAR_FUND_BIT])
    |=> flags_reg[FAR_FUND_BIT])
    else $error("fundamental flag lost");

  hot_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    flags_reg[FAR_HOT_BIT] && !(statusWrite && cfgWriteData[FAR_HOT_BIT])
    |=> flags_reg[FAR_HOT_BIT])
    else $error("hot flag lost");

  rev_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    flags_reg[REV_MISS_BIT] && !(statusWrite && cfgWriteData[REV_MISS_BIT])
    |=> flags_reg[REV_MISS_BIT])
    else $error("reverse miss flag lost");

  index_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    flags_reg[INDEX_ERR_BIT]
    && !(statusWrite && cfgWriteData[INDEX_ERR_BIT])
    |=> flags_reg[INDEX_ERR_BIT])
    else $error("index error flag lost");

  crc_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    flags_reg[CRC_FAIL_BIT] && !(statusWrite && cfgWriteData[CRC_FAIL_BIT])
    |=> flags_reg[CRC_FAIL_BIT])
    else $error("crc flag lost");

  window_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    flags_reg[WINDOW_BIT] && !(statusWrite && cfgWriteData[WINDOW_BIT])
    |=> flags_reg[WINDOW_BIT])
    else $error("window flag lost");

  // =====================================================================
  // checks: a clear flag stays clear without its event
  fund_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flags_reg[FAR_FUND_BIT] && !events.farFundReset
    |=> !flags_reg[FAR_FUND_BIT])
    else $error("fundamental flag set without event");

  hot_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flags_reg[FAR_HOT_BIT] && !events.farHotReset
    |=> !flags_reg[FAR_HOT_BIT])
    else $error("hot flag set without event");

  fwd_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flags_reg[FWD_MISS_BIT] && !events.fwdTableNoMatch
    |=> !flags_reg[FWD_MISS_BIT])
    else $error("forward miss flag set without event");

  rev_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flags_reg[REV_MISS_BIT] && !events.revTableNoMatch
    |=> !flags_reg[REV_MISS_BIT])
    else $error("reverse miss flag set without event");

  index_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flags_reg[INDEX_ERR_BIT] && !events.tableIndexError
    |=> !flags_reg[INDEX_ERR_BIT])
    else $error("index error flag set without event");

  crc_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flags_reg[CRC_FAIL_BIT] && !events.crcFail
    |=> !flags_reg[CRC_FAIL_BIT])
    else $error("crc flag set without event");

  window_quiet_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flags_reg[WINDOW_BIT] && !events.windowNoHit
    |=> !flags_reg[WINDOW_BIT])
    else $error("window flag set without event");

  // =====================================================================
  // checks: read port and mirrored outputs
  read_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
    !cfgRead |=> cfgReadData == 16'h0000)
    else $error("read data without read");

  status_read_a: assert property (@(posedge clock) disable iff (!reset_n)
    cfgRead && statusHit |=> cfgReadData == {8'h00, $past(statusView)})
    else $error("status read data wrong");

  id_read_a: assert property (@(posedge clock) disable iff (!reset_n)
    cfgRead && idHit |=> cfgReadData == $past(writerId_reg))
    else $error("writer id read data wrong");

  unmapped_read_a: assert property (@(posedge clock) disable iff (!reset_n)
    cfgRead && !statusHit && !idHit |=> cfgReadData == 16'h0000)
    else $error("unmapped read not zero");

  id_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    cfgWrite && idHit && !cfgWriteSeen.valid
    |=> writerId_reg == $past(writerId_reg))
    else $error("software write changed writer id");

  indicator_clean_a: assert property (@(posedge clock) disable iff (!reset_n)
    !flags_reg[FAR_ACTIVE_BIT])
    else $error("indicator bit stored as flag");

  status_mirror_a: assert property (@(posedge clock) disable iff (!reset_n)
    (statusOut & STICKY_MASK) == flags_reg)
    else $error("status output differs from flags");

  active_mirror_a: assert property (@(posedge clock) disable iff (!reset_n)
    statusOut[FAR_ACTIVE_BIT] == active_reg)
    else $error("status output indicator wrong");

  id_mirror_a: assert property (@(posedge clock) disable iff (!reset_n)
    writerIdOut == writerId_reg)
    else $error("writer id output differs");

endmodule : nsr_status_regs

//--- dv/testbench.sv
// random self-checking bench for the bridge status registers
`timescale 1ns/1ns
module testbench
  import nsr_pkg::*;
;
  // =========================================================
  // signals and model state
  logic              clock;
  logic              reset_n;
  logic              cfgWrite;
  logic              cfgRead;
  logic [11:0]       cfgAddr;
  logic [15:0]       cfgWriteData;
  logic [1:0]        cfgByteEn;
  logic [15:0]       cfgReadData;
  nsr_event_type     events;
  nsr_cfg_write_type cfgWriteSeen;
  logic [7:0]        statusOut;
  logic [15:0]       writerIdOut;
  logic [7:0]        expFlags;
  logic              expAct;
  logic [15:0]       expId;
  logic [31:0]       seed;
  int                fail_count;
  int                num_checks;

  nsr_status_regs u_nsr_status_regs (
    .clock(clock), .reset_n(reset_n), .cfgWrite(cfgWrite),
    .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWriteData(cfgWriteData),
    .cfgByteEn(cfgByteEn), .cfgReadData(cfgReadData), .events(events),
    .cfgWriteSeen(cfgWriteSeen), .statusOut(statusOut),
    .writerIdOut(writerIdOut)
  );

  // =========================================================
  // expectation helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // set wins over a same-cycle clear
  function automatic logic [7:0] nextFlags(input logic [7:0] f);
    logic [7:0] setv;
    logic [7:0] clr;
    setv = {events.windowNoHit, events.crcFail & ~events.crcConsumed,
      events.tableIndexError, events.revTableNoMatch,
      events.fwdTableNoMatch, 1'b0, events.farHotReset, events.farFundReset};
    clr = (cfgWrite && cfgAddr == STATUS_OFFSET && cfgByteEn[0]) ?
      cfgWriteData[7:0] & STICKY_MASK : 8'h00;
    return ((f & ~clr) | setv) & STICKY_MASK;
  endfunction : nextFlags

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk16

  // =========================================================
  // one clock of random traffic, checked against the model
  task automatic cycle;
    logic [7:0]  nf;
    logic [15:0] ni;
    logic [15:0] nr;
    logic [31:0] r;
    logic        na;
    nf = nextFlags(expFlags);
    na = events.farResetActive;
    ni = cfgWriteSeen.valid ? cfgWriteSeen.id : expId;
    nr = !cfgRead ? 16'h0000 : cfgAddr == STATUS_OFFSET ?
      {8'h00, expFlags | {5'h00, expAct, 2'h0}} :
      cfgAddr == WRITER_ID_OFFSET ? expId : 16'h0000;
    @(posedge clock);
    seed = xs(seed);
    r = seed;
    cfgWrite <= r[0] & r[1];
    cfgRead <= r[2];
    // mostly the status or writer id offset, otherwise a random offset in 0x000-0x0ff
    cfgAddr <= r[4] ? STATUS_OFFSET :
      r[3] ? WRITER_ID_OFFSET : {4'h0, r[12:5]};
    cfgWriteData <= r[28:13];
    cfgByteEn <= r[30:29];
    seed = xs(seed);
    events <= seed[8:0] & seed[17:9] & seed[26:18];
    seed = xs(seed);
    cfgWriteSeen <= {r[31], seed[15:0]};
    #1;
    chk8(statusOut, nf | {5'h00, na, 2'h0});
    chk16(writerIdOut, ni);
    chk16(cfgReadData, nr);
    expFlags = nf;
    expAct = na;
    expId = ni;
  endtask : cycle

  // reset from any state, inputs idle while it is held
  task automatic doReset;
    @(posedge clock);
    reset_n <= 1'b0;
    cfgWrite <= 1'b0;
    cfgRead <= 1'b0;
    events <= '0;
    cfgWriteSeen <= '0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    chk8(statusOut, STATUS_RESET);
    chk16(writerIdOut, WRITER_ID_RESET);
    expFlags = 8'h00;
    expAct = 1'b0;
    expId = 16'h0000;
  endtask : doReset

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // =========================================================
  // clock, main sequence, watchdog
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    {reset_n, cfgWrite, cfgRead, cfgAddr, cfgWriteData, cfgByteEn} = '0;
    events = '0;
    cfgWriteSeen = '0;
    seed = 32'h00000056;
    fail_count = 0;
    num_checks = 0;
    doReset();
    repeat (2000) cycle();
    // mid-run reset must clear flags and id
    doReset();
    repeat (2000) cycle();
    end_sim();
  end

  // run is about 4010 cycles of 100 ns
  initial begin
    #600000;
    fail_count++;
    end_sim();
  end
endmodule : testbench
